// ===== verilog/hfj_exec.sv
// execution unit for halt, fill, conditional jump, load address, load processor
// assumes a one-cycle-latency byte storage port and a decoded instruction pulse
// Operation
// - without dual level, halt branches to itself forever
// - with dual level enabled, halt passes control to alternate level
// - halt shows two identifier bytes on fourteen bar lights
// - identifier bits drive bars directly by bit position
// - panel reset clears halt and display, resumes next instruction
// - second-level halt loops until first halt cleared, then executes
// - halt inside interrupt level is ignored
// - loading halted level address register blanks display, resumes level
// - fill count is length minus one, leftmost first operand, one-byte fill
// - fill overwrites bytes left of first digit one to nine
// - fill scans left to right, stops on digit or end
// - recall register holds stop address until next recall-updating instruction
// - taken jump adds unsigned third byte to next address
// - bit0 set jumps on any tested one, else all zero
// - modifier bits two to seven select the six conditions
// - fixed modifier codes give no-op or unconditional jump
// - jump clears tested decimal-overflow and test-false bits
// - load address direct, or third byte plus an index register
// - modifier 01 targets first index, 02 second index
// - load processor copies two bytes, accepts diagnostics 21 to 23
// - diagnostics ignored while program-check level enabled
// - load-device modifier carries device address and address modifier
// - load-device modifier low bits name the target register
`timescale 1ns/1ps
`include "hfj_cfg.svh"
module hfj_exec
    import hfj_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    // clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_reset,
    // instruction issue
    input  wire logic              i_start,
    input  wire hfj_instr_t        i_instr,
    input  wire logic [ADDR_W-1:0] i_next_addr,
    input  wire logic              i_level,
    input  wire logic              i_in_interrupt,
    input  wire logic              i_dual_enabled,
    input  wire logic              i_pchk_enabled,
    input  wire logic              i_recall_touch,
    input  wire logic              i_cond_load,
    input  wire logic [5:0]        i_cond_in,
    // panel
    input  wire logic              i_halt_reset,
    // storage
    input  wire logic [7:0]        i_mem_rdata,
    input  wire logic [7:0]        i_fill_char,
    // outputs
    output logic                   o_done,
    output logic [ADDR_W-1:0]      o_next_addr,
    output logic                   o_level_switch,
    output logic                   o_loop_self,
    output logic [13:0]            o_bars,
    output logic [1:0]             o_halted,
    output logic [5:0]             o_cond,
    output logic [ADDR_W-1:0]      o_first_index_register,
    output logic [ADDR_W-1:0]      o_second_index_register,
    output logic [ADDR_W-1:0]      o_recall,
    output logic                   o_mem_rd,
    output logic                   o_mem_wr,
    output logic [ADDR_W-1:0]      o_mem_addr,
    output logic [7:0]             o_mem_wdata,
    output logic [ADDR_W-1:0]      o_lcp_data,
    output logic [7:0]             o_lcp_reg,
    output logic                   o_lcp_we,
    output logic [3:0]             o_lio_dev,
    output logic                   o_lio_mod,
    output logic [2:0]             o_lio_reg
);
    hfj_state_t        state_q;
    logic [7:0]        cnt_q;
    logic [ADDR_W-1:0] ptr_q;
    logic              take;
    logic [5:0]        cond_next;
    logic              is_halt;
    logic              is_jump;
    logic              is_la;
    logic              is_fill;
    logic              is_lcp;
    logic              diag_q;
    logic              other_halted;
    logic [ADDR_W-1:0] base;
    hfj_lio_q_t        lio_q;

    assign is_halt = i_instr.op == `HFJ_OP_HALT;
    assign is_jump = i_instr.op == `HFJ_OP_JUMP;
    assign is_la   = i_instr.op == `HFJ_OP_LA_DIR || i_instr.op == `HFJ_OP_LA_X1
                     || i_instr.op == `HFJ_OP_LA_X2;
    assign is_fill = i_instr.op[3:0] == `HFJ_FILL_NIB && i_instr.op[7:4] <= 4'hA;
    assign is_lcp  = i_instr.op[3:0] == `HFJ_LCP_NIB && i_instr.op[5:4] == 2'b11;
    assign other_halted = o_halted[~i_level];
    assign lio_q = hfj_lio_q_t'(i_instr.q);
    assign diag_q = i_instr.q == `HFJ_Q_DIAG20 || i_instr.q == `HFJ_Q_DIAG21
                    || i_instr.q == `HFJ_Q_DIAG22 || i_instr.q == `HFJ_Q_DIAG23
                    || i_instr.q == `HFJ_Q_DIAG30;

    always_comb
    begin
        if (i_instr.op == `HFJ_OP_LA_X1)
            base = o_first_index_register;
        else if (i_instr.op == `HFJ_OP_LA_X2)
            base = o_second_index_register;
        else
            base = '0;
    end

    hfj_jump_eval u_jump (
        .i_q         (i_instr.q),
        .i_cond      (o_cond),
        .o_take      (take),
        .o_cond_next (cond_next)
    );

    // sequencer for the multi-cycle fill
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            state_q <= HFJ_IDLE;
            cnt_q   <= 8'h00;
            ptr_q   <= '0;
        end
        else
        begin
            case (state_q)
                HFJ_IDLE:
                    if (i_start && is_fill)
                    begin
                        // leftmost address and length minus one
                        cnt_q   <= i_instr.q;
                        ptr_q   <= ADDR_W'({i_instr.r3, i_instr.r4});
                        state_q <= HFJ_FILL_RD;
                    end
                HFJ_FILL_RD:
                    state_q <= HFJ_FILL_WAIT;
                HFJ_FILL_WAIT:
                    // digits one to nine end the fill
                    if (i_mem_rdata[7:4] == `HFJ_ZONE_DIGIT && i_mem_rdata[3:0] >= 4'h1
                        && i_mem_rdata[3:0] <= 4'h9)
                        state_q <= HFJ_DONE;
                    else
                        state_q <= HFJ_FILL_WR;
                HFJ_FILL_WR:
                begin
                    // advance left to right until length used up
                    ptr_q <= ptr_q + ADDR_W'(1);
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00)
                        state_q <= HFJ_DONE;
                    else
                        state_q <= HFJ_FILL_RD;
                end
                default:
                    state_q <= HFJ_IDLE;
            endcase
        end
    end

    // storage port; operand 2 is only ever read by the caller
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_mem_rd    <= 1'b0;
            o_mem_wr    <= 1'b0;
            o_mem_addr  <= '0;
            o_mem_wdata <= 8'h00;
        end
        else
        begin
            o_mem_rd    <= state_q == HFJ_IDLE && i_start && is_fill
                           || state_q == HFJ_FILL_WR && cnt_q != 8'h00;
            // replace leading byte with fill character
            o_mem_wr    <= state_q == HFJ_FILL_WAIT && !(i_mem_rdata[7:4] == `HFJ_ZONE_DIGIT
                           && i_mem_rdata[3:0] >= 4'h1 && i_mem_rdata[3:0] <= 4'h9);
            o_mem_wdata <= i_fill_char;
            if (state_q == HFJ_IDLE && i_start && is_fill)
                o_mem_addr <= ADDR_W'({i_instr.r3, i_instr.r4});
            else if (state_q == HFJ_FILL_WR)
                o_mem_addr <= ptr_q + ADDR_W'(1);
        end
    end

    // recall register
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            o_recall <= '0;
        // stop address held; the fill itself overrides other updaters
        else if (state_q == HFJ_FILL_WAIT && o_mem_wr == 1'b0 && state_q != HFJ_FILL_WR
                 && i_mem_rdata[7:4] == `HFJ_ZONE_DIGIT && i_mem_rdata[3:0] >= 4'h1
                 && i_mem_rdata[3:0] <= 4'h9)
            o_recall <= ptr_q;
        else if (state_q == HFJ_FILL_WR && cnt_q == 8'h00)
            o_recall <= ptr_q + ADDR_W'(1);
        else if (i_recall_touch && state_q == HFJ_IDLE)
            o_recall <= i_next_addr;
    end

    // flow control, halt and display
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_done         <= 1'b0;
            o_next_addr    <= '0;
            o_level_switch <= 1'b0;
            o_loop_self    <= 1'b0;
            o_bars         <= 14'h0000;
            o_halted       <= 2'b00;
        end
        else
        begin
            o_done         <= state_q == HFJ_DONE || (i_start && !is_fill && state_q == HFJ_IDLE);
            o_level_switch <= 1'b0;
            o_loop_self    <= 1'b0;
            if (state_q == HFJ_IDLE && i_start)
            begin
                o_next_addr <= i_next_addr;
                // relative jump on unsigned third byte
                if (is_jump && take)
                    o_next_addr <= i_next_addr + ADDR_W'(i_instr.r3);
                // halt within interrupt sequence is a no-op
                if (is_halt && !i_in_interrupt)
                begin
                    if (other_halted)
                    begin
                        // wait on the second halt until the first clears
                        o_next_addr <= i_next_addr - ADDR_W'(3);
                        o_loop_self <= 1'b1;
                    end
                    else
                    begin
                        o_halted[i_level] <= 1'b1;
                        // bar lights follow byte bits 1 to 7 directly
                        o_bars <= {i_instr.q[6:0], i_instr.r3[6:0]};
                        if (i_dual_enabled)
                            // hand control to the alternate level
                            o_level_switch <= 1'b1;
                        else
                        begin
                            // branch to itself, following instruction never runs
                            o_next_addr <= i_next_addr - ADDR_W'(3);
                            o_loop_self <= 1'b1;
                        end
                    end
                end
                // address load of halted level releases it and blanks bars
                if (is_lcp && i_instr.q == `HFJ_Q_IAR && o_halted != 2'b00)
                begin
                    o_halted <= 2'b00;
                    o_bars   <= 14'h0000;
                end
            end
            // panel reset clears halt and identifier
            if (i_halt_reset && o_halted != 2'b00)
            begin
                o_halted <= 2'b00;
                o_bars   <= 14'h0000;
            end
        end
    end

    // condition register; outside instructions' results come in on the load port
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            o_cond <= 6'h00;
        // of these instructions only the jump touches conditions
        else if (state_q == HFJ_IDLE && i_start && is_jump)
            o_cond <= cond_next;
        else if (i_cond_load)
            o_cond <= i_cond_in;
    end

    // index registers
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_first_index_register  <= '0;
            o_second_index_register <= '0;
        end
        else if (state_q == HFJ_IDLE && i_start)
        begin
            if (is_la)
            begin
                // direct or displaced address into chosen index
                if (i_instr.q == `HFJ_Q_XR1)
                    o_first_index_register <= (i_instr.op == `HFJ_OP_LA_DIR)
                        ? ADDR_W'({i_instr.r3, i_instr.r4}) : base + ADDR_W'(i_instr.r3);
                else if (i_instr.q == `HFJ_Q_XR2)
                    o_second_index_register <= (i_instr.op == `HFJ_OP_LA_DIR)
                        ? ADDR_W'({i_instr.r3, i_instr.r4}) : base + ADDR_W'(i_instr.r3);
            end
        end
    end

    // processor register load and device qualifier split
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_lcp_we   <= 1'b0;
            o_lcp_reg  <= 8'h00;
            o_lcp_data <= '0;
            o_lio_dev  <= 4'h0;
            o_lio_mod  <= 1'b0;
            o_lio_reg  <= 3'h0;
        end
        else
        begin
            // copy operand, diagnostics blocked under program check
            o_lcp_we   <= state_q == HFJ_IDLE && i_start && is_lcp && !(diag_q && i_pchk_enabled);
            o_lcp_reg  <= i_instr.q;
            o_lcp_data <= ADDR_W'({i_instr.r3, i_instr.r4});
            // device, modifier and register code fields
            o_lio_dev  <= lio_q.dev;
            o_lio_mod  <= lio_q.modifier;
            o_lio_reg  <= lio_q.regsel;
        end
    end

    // panel reset must empty both halt flags and the display
    halt_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        i_halt_reset && o_halted != 2'b00 |=> o_halted == 2'b00 && o_bars == 14'h0000)
        else $error("halt reset did not clear");
    // halt in interrupt leaves halt flags alone
    halt_intr_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        state_q == HFJ_IDLE && i_start && is_halt && i_in_interrupt && !i_halt_reset
        |=> $stable(o_halted) && !o_loop_self && !o_level_switch)
        else $error("halt in interrupt acted");
    // jump target sum
    jump_target_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        state_q == HFJ_IDLE && i_start && is_jump && take
        |=> o_next_addr == $past(i_next_addr) + ADDR_W'($past(i_instr.r3)))
        else $error("jump target wrong");
    // fixed no-op codes never jump
    jump_noop_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        is_jump && (i_instr.q == 8'h80 || (!i_instr.q[7] && i_instr.q[2:0] == 3'h7))
        |-> !take)
        else $error("no-op code jumped");
    // conditions untouched by non-jump instructions; the load port brings outside results
    cond_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !(state_q == HFJ_IDLE && i_start && is_jump) && !i_cond_load |=> $stable(o_cond))
        else $error("condition changed");
    // self loop without dual level
    halt_loop_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        state_q == HFJ_IDLE && i_start && is_halt && !i_in_interrupt && !i_dual_enabled
        |=> o_loop_self && !o_level_switch)
        else $error("halt did not loop");
    // dual level switch
    halt_switch_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        state_q == HFJ_IDLE && i_start && is_halt && !i_in_interrupt && i_dual_enabled
        && !other_halted |=> o_level_switch)
        else $error("halt did not switch level");
    // diagnostics blocked
    lcp_diag_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        i_start && is_lcp && diag_q && i_pchk_enabled |=> !o_lcp_we)
        else $error("diagnostic load under program check");
    // fill write never follows the significant digit F5
    fill_stop_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        state_q == HFJ_FILL_WAIT && i_mem_rdata == 8'hF5 |=> !o_mem_wr ##1 state_q == HFJ_IDLE)
        else $error("fill ran past digit");
endmodule

// ===== verilog/hfj_cfg.svh
// constants for the halt/fill/jump/load execution block
// assumes one byte-wide storage port driven by the sequencer
`ifndef HFJ_CFG_SVH
`define HFJ_CFG_SVH
`define HFJ_OP_HALT      8'hF0
`define HFJ_OP_JUMP      8'hF2
`define HFJ_OP_LA_DIR    8'hC2
`define HFJ_OP_LA_X1     8'hD2
`define HFJ_OP_LA_X2     8'hE2
`define HFJ_FILL_NIB     4'hB
`define HFJ_LCP_NIB      4'hF
`define HFJ_Q_XR1        8'h01
`define HFJ_Q_XR2        8'h02
`define HFJ_Q_IAR        8'h08
`define HFJ_Q_DIAG20     8'h20
`define HFJ_Q_DIAG21     8'h21
`define HFJ_Q_DIAG22     8'h22
`define HFJ_Q_DIAG23     8'h23
`define HFJ_Q_DIAG30     8'h30
`define HFJ_ZONE_DIGIT   4'hF
`define HFJ_CR_BOVF      0
`define HFJ_CR_TFALSE    1
`define HFJ_CR_DOVF      2
`define HFJ_CR_HIGH      3
`define HFJ_CR_LOW       4
`define HFJ_CR_EQUAL     5
`define HFJ_LIO_DEV_MSB  7
`define HFJ_LIO_DEV_LSB  4
`define HFJ_LIO_MOD_BIT  3
`define HFJ_LIO_REG_MSB  2
`define HFJ_LIO_REG_LSB  0
`endif

// ===== verilog/hfj_pkg.sv
// types for the halt/fill/jump/load execution block
package hfj_pkg;
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] q;
        logic [7:0] r3;
        logic [7:0] r4;
    } hfj_instr_t;
    typedef struct packed {
        logic [3:0] dev;
        logic       modifier;
        logic [2:0] regsel;
    } hfj_lio_q_t;
    typedef enum {HFJ_IDLE, HFJ_FILL_RD, HFJ_FILL_WAIT, HFJ_FILL_WR, HFJ_DONE} hfj_state_t;
endpackage

// ===== verilog/hfj_jump_eval.sv
// jump-on-condition decision and condition clearing
// assumes condition bits in order bovf,tfalse,dovf,high,low,equal (bit 0 first)
`timescale 1ns/1ps
`include "hfj_cfg.svh"
module hfj_jump_eval
    import hfj_pkg::*;
(
    // inputs
    input  wire logic [7:0] i_q,
    input  wire logic [5:0] i_cond,
    // outputs
    output logic            o_take,
    output logic [5:0]      o_cond_next
);
    logic [5:0] sel;
    always_comb
    begin
        // q bit 2 tests bovf ... q bit 7 tests equal (q bit 7 = lsb of byte)
        sel = {i_q[0], i_q[1], i_q[2], i_q[3], i_q[4], i_q[5]};
        if (i_q[7])
            o_take = |(sel & i_cond);
        else
            o_take = ~|(sel & i_cond);
        if (i_q[3:0] == 4'h7 || i_q[3:0] == 4'hF)
            o_take = i_q[7];
        if (i_q == 8'h80)
            o_take = 1'b0;
        if (i_q == 8'h00)
            o_take = 1'b1;
        // clear tested dovf and tfalse only
        o_cond_next = i_cond;
        if (sel[`HFJ_CR_DOVF])
            o_cond_next[`HFJ_CR_DOVF] = 1'b0;
        if (sel[`HFJ_CR_TFALSE])
            o_cond_next[`HFJ_CR_TFALSE] = 1'b0;
    end
endmodule

// ===== verification/hfj_store_model.sv
// storage model on the far side of the execution block
// assumes one-cycle read and write pulses from the block
`timescale 1ns/1ps
module hfj_store_model
(
    // clock
    input  wire logic        i_ref_clk,
    // access
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    // read data
    output logic      [7:0]  o_rdata
);
    logic [7:0] mem [256];
    // data holds one cycle only; the toggling exposes a late sample
    always @(posedge i_ref_clk)
    begin
        if (i_rd)
            o_rdata <= mem[i_addr[7:0]];
        else
            o_rdata <= ~o_rdata;
        if (i_wr)
            mem[i_addr[7:0]] <= i_wdata;
    end
endmodule

// ===== verification/tb.sv
// self-checking bench for the halt/fill/jump/load execution block
// assumes the storage model beside it and inputs driven at falling edges
`timescale 1ns/1ps
module tb
    import hfj_pkg::*;
;
    logic clk, reset, start, level, in_int, dual, pchk, touch, hrst, poke, cld;
    logic done, lsw, loop, rd, wr, we, mod, saw_sw, saw_loop, saw_we;
    hfj_instr_t  instr;
    logic [15:0] na, nxt, xr1, xr2, recall, maddr, ldata;
    logic [13:0] bars;
    logic [7:0]  fchar, rdata, wdata, lreg;
    logic [5:0]  cond, cin;
    logic [3:0]  dev;
    logic [2:0]  lio_reg;
    logic [1:0]  halted;
    int          fail_count = 0;
    int          n_checks = 0;
    logic [7:0]  jq [9] = '{8'h00, 8'h80, 8'h30, 8'hB0, 8'h07, 8'h0F, 8'h87, 8'hFF, 8'h77};
    logic        jt [9] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [7:0]  f0 [6] = '{8'h40, 8'hF0, 8'h40, 8'hF5, 8'hF0, 8'hF3};
    logic [7:0]  f1 [6] = '{8'h5B, 8'h5B, 8'h5B, 8'hF5, 8'hF0, 8'hF3};

    hfj_exec u_dut (.i_ref_clk(clk), .i_reset(reset), .i_start(start), .i_instr(instr),
        .i_next_addr(na), .i_level(level), .i_in_interrupt(in_int), .i_dual_enabled(dual),
        .i_pchk_enabled(pchk), .i_recall_touch(touch), .i_halt_reset(hrst),
        .i_cond_load(cld), .i_cond_in(cin),
        .i_mem_rdata(rdata), .i_fill_char(fchar), .o_done(done), .o_next_addr(nxt),
        .o_level_switch(lsw), .o_loop_self(loop), .o_bars(bars), .o_halted(halted),
        .o_cond(cond), .o_first_index_register(xr1), .o_second_index_register(xr2),
        .o_recall(recall), .o_mem_rd(rd), .o_mem_wr(wr), .o_mem_addr(maddr),
        .o_mem_wdata(wdata), .o_lcp_data(ldata), .o_lcp_reg(lreg), .o_lcp_we(we),
        .o_lio_dev(dev), .o_lio_mod(mod), .o_lio_reg(lio_reg));

    hfj_store_model u_mem (.i_ref_clk(clk), .i_rd(rd), .i_wr(wr), .i_addr(maddr),
        .i_wdata(wdata), .o_rdata(rdata));

    // pulses are remembered so that they can be checked after completion
    always @(posedge clk)
    begin
        if (lsw) saw_sw = 1'b1;
        if (loop) saw_loop = 1'b1;
        if (we) saw_we = 1'b1;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one instruction, then wait for completion; poke tries a start while busy
    task automatic issue(input logic [7:0] op, q, r3, r4, input logic [15:0] a);
        int n;
        n = 0;
        saw_sw = 1'b0;
        saw_loop = 1'b0;
        saw_we = 1'b0;
        instr = '{op, q, r3, r4};
        na = a;
        start = 1'b1;
        @(negedge clk);
        if (poke)
        begin
            instr = '{8'hC2, 8'h01, 8'hFF, 8'hFF};
            @(negedge clk);
        end
        start = 1'b0;
        while (done !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        check("done", n < 200, 1);
        // one more edge so that registered pulses reach the saw flags
        @(negedge clk);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        #400000;
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        {start, level, in_int, dual, pchk, touch, hrst, poke, cld, cin} = '0;
        instr = '0;
        na = '0;
        fchar = 8'h5B;
        reset = 1'b1;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        check("halted", halted, 0);
        check("bars", bars, 0);
        for (int i = 0; i < 9; i++)
        begin
            issue(8'hF2, jq[i], 8'h0F, 8'h00, 16'h0BC0);
            check("jump_addr", nxt, jt[i] ? 16'h0BCF : 16'h0BC0);
            check("jump_cond", cond, 0);
        end
        cld = 1'b1;
        cin = 6'h16;
        @(negedge clk);
        cld = 1'b0;
        issue(8'hF2, 8'h90, 8'h0F, 8'h00, 16'h0BC0);
        check("jump_any", {nxt, cond}, {16'h0BCF, 6'h14});
        issue(8'hF2, 8'h08, 8'h0F, 8'h00, 16'h0BC0);
        check("jump_all", {nxt, cond}, {16'h0BC0, 6'h10});
        issue(8'hF2, 8'h82, 8'h0F, 8'h00, 16'h0BC0);
        check("jump_low", {nxt, cond}, {16'h0BCF, 6'h10});
        issue(8'hC2, 8'h01, 8'h12, 8'h34, 16'h0);
        check("xr1", xr1, 16'h1234);
        issue(8'hD2, 8'h02, 8'h05, 8'h00, 16'h0);
        check("xr2", xr2, 16'h1239);
        issue(8'hE2, 8'h01, 8'hF0, 8'h00, 16'h0);
        check("xr1", xr1, 16'h1329);
        issue(8'h31, 8'hA5, 8'h00, 8'h00, 16'h0);
        check("lio", {dev, mod, lio_reg}, 8'hA5);
        issue(8'h31, 8'h5E, 8'h00, 8'h00, 16'h0);
        check("lio", {dev, mod, lio_reg}, 8'h5E);
        for (int k = 8'h21; k <= 8'h23; k++)
        begin
            issue(8'h3F, k[7:0], 8'hAB, 8'hCD, 16'h0);
            check("lcp", {saw_we, lreg, ldata}, {1'b1, k[7:0], 16'hABCD});
        end
        pchk = 1'b1;
        issue(8'h3F, 8'h20, 8'h00, 8'h00, 16'h0);
        check("lcp_we", saw_we, 0);
        issue(8'h3F, 8'h30, 8'h00, 8'h00, 16'h0);
        check("lcp_we", saw_we, 0);
        pchk = 1'b0;
        issue(8'hF0, 8'h6F, 8'h03, 8'h00, 16'h0103);
        check("halt_loop", {saw_loop, nxt}, {1'b1, 16'h0100});
        check("bars", bars, {7'h6F, 7'h03});
        check("halted", halted, 2'b01);
        level = 1'b1;
        dual = 1'b1;
        issue(8'hF0, 8'h76, 8'h03, 8'h00, 16'h0203);
        check("second_halt", {saw_loop, saw_sw, halted}, {2'b10, 2'b01});
        hrst = 1'b1;
        @(negedge clk);
        hrst = 1'b0;
        @(negedge clk);
        check("halt_reset", {halted, bars}, 0);
        issue(8'hF0, 8'h76, 8'h03, 8'h00, 16'h0203);
        check("level_switch", {saw_sw, halted}, 3'b110);
        check("bars", bars, {7'h76, 7'h03});
        in_int = 1'b1;
        issue(8'h3F, 8'h08, 8'h00, 8'h40, 16'h0);
        check("release", {halted, bars}, 0);
        issue(8'hF0, 8'h7F, 8'h7F, 8'h00, 16'h0303);
        check("int_halt", {saw_loop, saw_sw, halted, bars}, 0);
        {in_int, level, dual} = '0;
        for (int i = 0; i < 6; i++) u_mem.mem[8'h10 + i] = f0[i];
        {u_mem.mem[8'h20], u_mem.mem[8'h21], u_mem.mem[8'h22]} = 24'hF040FA;
        u_mem.mem[8'h23] = 8'hF1;
        poke = 1'b1;
        issue(8'h0B, 8'h05, 8'h00, 8'h10, 16'h0200);
        poke = 1'b0;
        for (int i = 0; i < 6; i++) check("fill1", u_mem.mem[8'h10 + i], f1[i]);
        check("recall", recall, 16'h0013);
        check("busy_start", xr1, 16'h1329);
        issue(8'h0B, 8'h02, 8'h00, 8'h20, 16'h0300);
        check("fill2", {u_mem.mem[8'h20], u_mem.mem[8'h21], u_mem.mem[8'h22]}, 24'h5B5B5B);
        check("fill2_end", u_mem.mem[8'h23], 8'hF1);
        check("recall", recall, 16'h0023);
        na = 16'h4321;
        touch = 1'b1;
        @(negedge clk);
        touch = 1'b0;
        @(negedge clk);
        check("recall", recall, 16'h4321);
        check("cond", cond, 6'h10);
        tally_and_finish();
    end
endmodule
